// ===== design/beep_report_sequencer.sv
// beep report sequencer: power-up report, continuity loop, post-flight loop
// assumes a plain register port, inputs synchronous to clk, one 40 MHz clock
//
// Functional notes
// - each number: one long separator, then a short-beep group per digit
// - digit zero is played as ten short beeps
// - digits go most significant first, longer pause between digit places
// - power-up opens with the active preset number, one digit 1..9
// - default preset is 3, main altitude 700 feet, no apogee delay
// - two second pause, then main deployment altitude 100..9999 feet
// - nonzero apogee delay adds two second pause and five second tone
// - two second pause, then stored apogee of the previous flight
// - power loss plays warbling siren instead; flag clears after good flight
// - two second pause, then battery voltage in tenths of a volt
// - continuity code every 0.8 s: 1 drogue, 2 main, 3 both, else silent
// - optional power-up delay lengthens the pause before continuity
// - during continuity the ground pressure reference follows until launch
// - after landing: extra-long tone, then peak altitude in feet
// - maximum velocity and its separator are played at higher pitch
// - nonzero siren delay: wait, then 10 s warble siren; zero disables
// - then 10 s silence and the whole report repeats forever
// - flight records and peak altitude are kept without reset
// - main firing has no effect without supply and is never retried
// - main fires during descent when altitude falls to the preset altitude
`timescale 1ns/10ps

module beep_report_sequencer
  import beep_report_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 4_000_000,
  parameter int unsigned SEP_CYC = 20_000_000,
  parameter int unsigned GAP_CYC = 4_000_000,
  parameter int unsigned DIGIT_GAP_CYC = 20_000_000,
  parameter int unsigned XLONG_CYC = 80_000_000,
  parameter int unsigned SEC_CYC = CLK_HZ / 1000 * SEC_MS,
  parameter int unsigned PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS,
  parameter int unsigned WARN_CYC = CLK_HZ / 1000 * WARN_MS,
  parameter int unsigned SIREN_CYC = CLK_HZ / 1000 * SIREN_MS,
  parameter int unsigned SILENCE_CYC = CLK_HZ / 1000 * SILENCE_MS,
  parameter int unsigned CONT_CYC = CLK_HZ / 1000 * CONT_MS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_ff,
  // flight sensing
  input wire logic supply_ok,
  input wire logic drogue_cont,
  input wire logic main_cont,
  input wire logic descending,
  input wire logic [16:0] alt_ft,
  input wire logic [23:0] pressure,
  // beeper and ejection
  output logic beep_on_ff,
  output logic [1:0] tone_kind_ff,
  output logic main_fire_ff
);

  typedef enum logic [3:0] {
    P_PRESET, P_MDA, P_WARN, P_LAST, P_BATT, P_CONT,
    F_LONG, F_PEAK, F_VEL, F_SIREN, F_SILENCE, S_IDLE
  } step_e;

  typedef enum logic [3:0] {
    M_START, M_PAUSE, M_SEP, M_SEP_GAP, M_BEEP, M_BEEP_GAP, M_DIG_GAP,
    M_TONE, M_CONT, M_HALT
  } micro_e;

  typedef enum logic [1:0] {ACT_NONE, ACT_NUM, ACT_TONE, ACT_CONT} act_e;

  function automatic logic [16:0] pow10(input logic [2:0] p);
    case (p)
      3'h0: pow10 = 17'h00001;
      3'h1: pow10 = 17'h0000A;
      3'h2: pow10 = 17'h00064;
      3'h3: pow10 = 17'h003E8;
      3'h4: pow10 = 17'h02710;
      default: pow10 = 17'h186A0;
    endcase
  endfunction : pow10

  function automatic logic [3:0] digit_at(input logic [16:0] v, input logic [2:0] p);
    logic [16:0] q;
    q = v / pow10(p);
    digit_at = 4'(q % 17'h0000A);
  endfunction : digit_at

  // index of the leading digit; leading zeros are never played
  function automatic logic [2:0] top_digit(input logic [16:0] v);
    top_digit = 3'h0;
    for (int i = 1; i < 6; i++)
    begin
      if (v >= pow10(3'(i)))
        top_digit = 3'(i);
    end
  endfunction : top_digit

  function automatic logic [13:0] default_mda(input int i);
    case (i)
      1: default_mda = 14'h012C;
      2: default_mda = 14'h01F4;
      3: default_mda = 14'h02BC;
      4: default_mda = 14'h0384;
      5: default_mda = 14'h044C;
      6: default_mda = 14'h0514;
      7: default_mda = 14'h05DC;
      8: default_mda = 14'h06A4;
      default: default_mda = 14'h09C4;
    endcase
  endfunction : default_mda

  // settings
  logic [3:0] preset_ff;
  logic [13:0] mda_mem [1:9];
  logic [2:0] apo_mem [1:9];
  logic [7:0] siren_dly_ff;
  logic [7:0] pup_dly_ff;
  // records kept across power loss; the battery reading batt_ff is reset
  logic [16:0] last_apo_nv;
  logic [16:0] peak_nv;
  logic [16:0] max_vel_nv;
  logic power_lost_nv;
  logic [7:0] batt_ff;
  // flight state
  logic flying_ff;
  logic lost_now_ff;
  logic fired_ff;
  logic [23:0] ground_ff;
  // sequencer
  step_e step_ff;
  micro_e mst_ff;
  logic [31:0] tmr_ff;
  logic [31:0] per_ff;
  logic [3:0] beeps_ff;
  logic [2:0] dig_ff;
  logic [16:0] val_ff;
  logic cont_mode_ff;
  logic [1:0] kind_ff;

  logic wr_ctrl;
  logic land_evt;
  logic launch_evt;
  logic [13:0] cur_mda;
  logic [2:0] cur_apo;
  logic [13:0] mda_in;
  logic [2:0] apo_in;
  logic [31:0] cur_pause;
  logic [31:0] cur_tone;
  logic [16:0] cur_val;
  logic [1:0] cur_kind;
  act_e cur_act;
  step_e next_step;
  logic [3:0] dig_beeps;
  logic [1:0] cont_code;

  assign wr_ctrl = wr_en && (addr == A_CTRL);
  assign land_evt = wr_ctrl && wdata[CTRL_LAND_BIT];
  assign launch_evt = wr_ctrl && wdata[CTRL_LAUNCH_BIT];
  assign cur_mda = mda_mem[preset_ff];
  assign cur_apo = apo_mem[preset_ff];
  assign mda_in = (wdata[31:14] != 18'h00000 || wdata[13:0] > MDA_MAX) ? MDA_MAX :
                  (wdata[13:0] < MDA_MIN) ? MDA_MIN : wdata[13:0];
  assign apo_in = (wdata[31:3] != 29'h00000000 || wdata[2:0] > APO_DLY_MAX) ?
                  APO_DLY_MAX : wdata[2:0];
  assign dig_beeps = (digit_at(val_ff, dig_ff) == 4'h0) ? 4'hA :
                     digit_at(val_ff, dig_ff);
  assign cont_code = {main_cont, drogue_cont};

  // register writes to settings and records
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preset_ff <= PRESET_RST;
      siren_dly_ff <= SIREN_DLY_RST;
      pup_dly_ff <= PUP_DLY_RST;
      batt_ff <= 8'h00;
      for (int i = 1; i <= 9; i++)
      begin
        mda_mem[i] <= default_mda(i);
        apo_mem[i] <= 3'h0;
      end
    end
    else if (wr_en)
    begin
      case (addr)
        A_PRESET:
          if (wdata[3:0] != 4'h0 && wdata[3:0] <= PRESET_MAX && wdata[31:4] == 28'h0000000)
            preset_ff <= wdata[3:0];
        A_MDA: mda_mem[preset_ff] <= mda_in;
        A_APO_DLY: apo_mem[preset_ff] <= apo_in;
        A_BATT: batt_ff <= wdata[7:0];
        A_SIREN_DLY: siren_dly_ff <= wdata[7:0];
        A_PUP_DLY: pup_dly_ff <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // no reset here: these stand in for nonvolatile storage
  always_ff @(posedge clk)
  begin
    if (wr_en && addr == A_LAST_APO)
      last_apo_nv <= wdata[16:0];
    if (wr_en && addr == A_PEAK)
      peak_nv <= wdata[16:0];
    if (wr_en && addr == A_MAX_VEL)
      max_vel_nv <= wdata[16:0];
    if (land_evt)
      power_lost_nv <= lost_now_ff;
    else if (wr_en && addr == A_FLAGS)
      power_lost_nv <= wdata[0];
  end

  // flight state, supply watch and main ejection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flying_ff <= 1'b0;
      lost_now_ff <= 1'b0;
      fired_ff <= 1'b0;
      main_fire_ff <= 1'b0;
    end
    else
    begin
      if (launch_evt)
      begin
        flying_ff <= 1'b1;
        // a loss in the launch cycle itself counts only if already flying; otherwise the flag clears
        lost_now_ff <= flying_ff && !supply_ok;
      end
      else if (land_evt)
        flying_ff <= 1'b0;
      else if (flying_ff && !supply_ok)
        lost_now_ff <= 1'b1;
      // one attempt only; a dead supply at that moment wastes it
      if (flying_ff && descending && !fired_ff && alt_ft <= 17'(cur_mda))
      begin
        fired_ff <= 1'b1;
        main_fire_ff <= supply_ok;
      end
    end
  end

  // ground reference tracks only while continuity is reported
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ground_ff <= 24'h000000;
    else if (mst_ff == M_CONT || (step_ff == P_CONT && cont_mode_ff))
      ground_ff <= pressure;
  end

  // per-step plan: pause before, what to play, and the step after
  always_comb
  begin
    cur_pause = PAUSE_CYC;
    cur_act = ACT_NUM;
    cur_val = 17'h00000;
    cur_kind = TONE_NORMAL;
    cur_tone = WARN_CYC;
    next_step = S_IDLE;
    case (step_ff)
      P_PRESET:
      begin
        cur_pause = 32'h00000000;
        cur_val = 17'(preset_ff);
        next_step = P_MDA;
      end
      P_MDA:
      begin
        cur_val = 17'(cur_mda);
        next_step = (cur_apo != 3'h0) ? P_WARN : P_LAST;
      end
      P_WARN:
      begin
        cur_act = ACT_TONE;
        next_step = P_LAST;
      end
      P_LAST:
      begin
        cur_val = last_apo_nv;
        if (power_lost_nv)
        begin
          cur_act = ACT_TONE;
          cur_kind = TONE_WARBLE;
          cur_tone = SIREN_CYC;
        end
        next_step = P_BATT;
      end
      P_BATT:
      begin
        cur_val = 17'(batt_ff);
        next_step = P_CONT;
      end
      P_CONT:
      begin
        cur_pause = PAUSE_CYC + 32'(pup_dly_ff) * SEC_CYC;
        cur_act = ACT_CONT;
      end
      F_LONG:
      begin
        cur_pause = 32'h00000000;
        cur_act = ACT_TONE;
        cur_tone = XLONG_CYC;
        next_step = F_PEAK;
      end
      F_PEAK:
      begin
        cur_pause = 32'h00000000;
        cur_val = peak_nv;
        next_step = F_VEL;
      end
      F_VEL:
      begin
        cur_pause = 32'h00000000;
        cur_val = max_vel_nv;
        cur_kind = TONE_HIGH;
        next_step = (siren_dly_ff != 8'h00) ? F_SIREN : F_SILENCE;
      end
      F_SIREN:
      begin
        cur_pause = 32'(siren_dly_ff) * SEC_CYC;
        cur_act = ACT_TONE;
        cur_kind = TONE_WARBLE;
        cur_tone = SIREN_CYC;
        next_step = F_SILENCE;
      end
      F_SILENCE:
      begin
        cur_pause = SILENCE_CYC;
        cur_act = ACT_NONE;
        next_step = F_LONG;
      end
      default:
      begin
        cur_pause = 32'h00000000;
        cur_act = ACT_NONE;
      end
    endcase
  end

  // continuity period counter runs freely once reporting starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      per_ff <= 32'h00000000;
    else if (!cont_mode_ff || per_ff == 32'h00000000)
      per_ff <= CONT_CYC - 32'h00000001;
    else
      per_ff <= per_ff - 32'h00000001;
  end

  // step and beep sequencer; restarts with the preset at every power-up
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_ff <= P_PRESET;
      mst_ff <= M_START;
      tmr_ff <= 32'h00000000;
      beeps_ff <= 4'h0;
      dig_ff <= 3'h0;
      val_ff <= 17'h00000;
      cont_mode_ff <= 1'b0;
      kind_ff <= TONE_NORMAL;
    end
    else if (land_evt)
    begin
      step_ff <= F_LONG;
      mst_ff <= M_START;
      cont_mode_ff <= 1'b0;
    end
    else if (launch_evt)
    begin
      step_ff <= S_IDLE;
      mst_ff <= M_HALT;
      cont_mode_ff <= 1'b0;
    end
    else
    begin
      if (tmr_ff != 32'h00000000)
        tmr_ff <= tmr_ff - 32'h00000001;
      case (mst_ff)
        M_START:
        begin
          val_ff <= cur_val;
          dig_ff <= top_digit(cur_val);
          kind_ff <= cur_kind;
          tmr_ff <= cur_pause;
          mst_ff <= (step_ff == S_IDLE) ? M_HALT : M_PAUSE;
        end
        M_PAUSE:
          if (tmr_ff == 32'h00000000)
          begin
            case (cur_act)
              ACT_NUM:
              begin
                tmr_ff <= SEP_CYC - 32'h00000001;
                mst_ff <= M_SEP;
              end
              ACT_TONE:
              begin
                tmr_ff <= cur_tone - 32'h00000001;
                mst_ff <= M_TONE;
              end
              ACT_CONT:
              begin
                cont_mode_ff <= 1'b1;
                mst_ff <= M_CONT;
              end
              default:
              begin
                step_ff <= next_step;
                mst_ff <= M_START;
              end
            endcase
          end
        M_SEP:
          if (tmr_ff == 32'h00000000)
          begin
            tmr_ff <= GAP_CYC - 32'h00000001;
            mst_ff <= M_SEP_GAP;
          end
        M_SEP_GAP:
          if (tmr_ff == 32'h00000000)
          begin
            beeps_ff <= dig_beeps;
            tmr_ff <= SHORT_CYC - 32'h00000001;
            mst_ff <= M_BEEP;
          end
        M_BEEP:
          if (tmr_ff == 32'h00000000)
          begin
            beeps_ff <= beeps_ff - 4'h1;
            tmr_ff <= GAP_CYC - 32'h00000001;
            mst_ff <= M_BEEP_GAP;
          end
        M_BEEP_GAP:
          if (tmr_ff == 32'h00000000)
          begin
            if (beeps_ff != 4'h0)
            begin
              tmr_ff <= SHORT_CYC - 32'h00000001;
              mst_ff <= M_BEEP;
            end
            else if (cont_mode_ff)
              mst_ff <= M_CONT;
            else if (dig_ff != 3'h0)
            begin
              dig_ff <= dig_ff - 3'h1;
              tmr_ff <= DIGIT_GAP_CYC - 32'h00000001;
              mst_ff <= M_DIG_GAP;
            end
            else
            begin
              step_ff <= next_step;
              mst_ff <= M_START;
            end
          end
        M_DIG_GAP:
          if (tmr_ff == 32'h00000000)
          begin
            beeps_ff <= dig_beeps;
            tmr_ff <= SHORT_CYC - 32'h00000001;
            mst_ff <= M_BEEP;
          end
        M_TONE:
          if (tmr_ff == 32'h00000000)
          begin
            step_ff <= next_step;
            mst_ff <= M_START;
          end
        M_CONT:
          // silent when neither circuit is continuous
          if (per_ff == 32'h00000000 && cont_code != 2'h0)
          begin
            beeps_ff <= {2'h0, cont_code};
            tmr_ff <= SHORT_CYC - 32'h00000001;
            mst_ff <= M_BEEP;
          end
        M_HALT: ;
        default: mst_ff <= M_HALT;
      endcase
    end
  end

  // beeper drive lags the sequencer state by one clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      beep_on_ff <= 1'b0;
      tone_kind_ff <= TONE_NORMAL;
    end
    else
    begin
      beep_on_ff <= (mst_ff == M_SEP) || (mst_ff == M_BEEP) || (mst_ff == M_TONE);
      tone_kind_ff <= cont_mode_ff ? TONE_NORMAL : kind_ff;
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 32'h00000000;
    else if (!rd_en)
      rdata_ff <= 32'h00000000;
    else
    begin
      case (addr)
        A_CTRL: rdata_ff <= {20'h00000, step_ff, mst_ff, 2'h0, cont_mode_ff, flying_ff};
        A_PRESET: rdata_ff <= {28'h0000000, preset_ff};
        A_MDA: rdata_ff <= {18'h00000, cur_mda};
        A_APO_DLY: rdata_ff <= {29'h00000000, cur_apo};
        A_LAST_APO: rdata_ff <= {15'h0000, last_apo_nv};
        A_PEAK: rdata_ff <= {15'h0000, peak_nv};
        A_MAX_VEL: rdata_ff <= {15'h0000, max_vel_nv};
        A_BATT: rdata_ff <= {24'h000000, batt_ff};
        A_FLAGS: rdata_ff <= {30'h00000000, lost_now_ff, power_lost_nv};
        A_SIREN_DLY: rdata_ff <= {24'h000000, siren_dly_ff};
        A_PUP_DLY: rdata_ff <= {24'h000000, pup_dly_ff};
        A_GROUND: rdata_ff <= {8'h00, ground_ff};
        A_MAIN: rdata_ff <= {30'h00000000, fired_ff, main_fire_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

endmodule : beep_report_sequencer

// ===== design/beep_report_pkg.sv
// constants for the audible report sequencer: register map, field layout,
// reset values and documented times; shared by design and bench
package beep_report_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // documented times in milliseconds
  localparam int unsigned PAUSE_MS = 2000;
  localparam int unsigned WARN_MS = 5000;
  localparam int unsigned SIREN_MS = 10000;
  localparam int unsigned SILENCE_MS = 10000;
  localparam int unsigned CONT_MS = 800;
  localparam int unsigned SEC_MS = 1000;

  // register word addresses
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_PRESET = 4'h1;
  localparam logic [3:0] A_MDA = 4'h2;
  localparam logic [3:0] A_APO_DLY = 4'h3;
  localparam logic [3:0] A_LAST_APO = 4'h4;
  localparam logic [3:0] A_PEAK = 4'h5;
  localparam logic [3:0] A_MAX_VEL = 4'h6;
  localparam logic [3:0] A_BATT = 4'h7;
  localparam logic [3:0] A_FLAGS = 4'h8;
  localparam logic [3:0] A_SIREN_DLY = 4'h9;
  localparam logic [3:0] A_PUP_DLY = 4'hA;
  localparam logic [3:0] A_GROUND = 4'hB;
  localparam logic [3:0] A_MAIN = 4'hC;

  // control register bits
  localparam int CTRL_LAND_BIT = 1;
  localparam int CTRL_LAUNCH_BIT = 2;

  // reset values and limits
  localparam logic [3:0] PRESET_RST = 4'h3;
  localparam logic [3:0] PRESET_MAX = 4'h9;
  localparam logic [13:0] MDA_MIN = 14'h0064;
  localparam logic [13:0] MDA_MAX = 14'h270F;
  localparam logic [2:0] APO_DLY_MAX = 3'h5;
  localparam logic [7:0] SIREN_DLY_RST = 8'h05;
  localparam logic [7:0] PUP_DLY_RST = 8'h00;

  typedef enum logic [1:0] {TONE_NORMAL, TONE_HIGH, TONE_WARBLE} tone_e;

endpackage : beep_report_pkg

// ===== verif/beeper_listener.sv
// listener model: turns the beeper output into a list of heard tone runs
// assumes beep and tone outputs are registered on clk
`timescale 1ns/10ps

module beeper_listener
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // beeper
  input wire logic beep_on_ff,
  input wire logic [1:0] tone_kind_ff
);
  int run_len[$];
  int run_tone[$];
  int rises;
  int cur_len;
  logic [1:0] cur_tone;

  // a person only judges a tone once it ends, so a run is logged at its end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_len = 0;
    else if (beep_on_ff)
    begin
      if (cur_len == 0)
      begin
        rises = rises + 1;
        cur_tone = tone_kind_ff;
      end
      cur_len = cur_len + 1;
    end
    else if (cur_len != 0)
    begin
      run_len.push_back(cur_len);
      run_tone.push_back(int'(cur_tone));
      cur_len = 0;
    end
  end
endmodule : beeper_listener

// ===== verif/beep_report_sequencer_sva.sv
// checker for the beep report sequencer, bound to its ports
// assumes one clock domain and the run lengths given as parameters
`timescale 1ns/10ps

module beep_report_sequencer_chk
  import beep_report_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 2,
  parameter int unsigned SEP_CYC = 4,
  parameter int unsigned XLONG_CYC = 6,
  parameter int unsigned WARN_CYC = 7,
  parameter int unsigned SIREN_CYC = 9
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata_ff,
  // flight sensing
  input wire logic supply_ok,
  input wire logic descending,
  input wire logic [16:0] alt_ft,
  // beeper and ejection
  input wire logic beep_on_ff,
  input wire logic [1:0] tone_kind_ff,
  input wire logic main_fire_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] run_ff;
  logic len_ok;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_ff <= 32'h0;
    else if (beep_on_ff)
      run_ff <= run_ff + 32'h1;
    else
      run_ff <= 32'h0;
  end

  // only documented tone lengths may ever be heard
  assign len_ok = run_ff == SHORT_CYC || run_ff == SEP_CYC || run_ff == XLONG_CYC
    || run_ff == WARN_CYC || run_ff == SIREN_CYC;

  sequence beep_start;
    !beep_on_ff ##1 beep_on_ff;
  endsequence
  sequence launch_write;
    wr_en && addr == A_CTRL && wdata[CTRL_LAUNCH_BIT] && !wdata[CTRL_LAND_BIT];
  endsequence
  sequence quiet_run;
    !beep_on_ff [*4];
  endsequence

  chk_rdata_idle: assert property (!rd_en |=> rdata_ff == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_run_length: assert property ($fell(beep_on_ff) |-> len_ok)
    else $error("tone run of undocumented length");
  chk_beep_min: assert property (beep_start |-> beep_on_ff [*2])
    else $error("beep shorter than a short beep");
  chk_tone_stable: assert property (beep_on_ff && $past(beep_on_ff) |-> $stable(tone_kind_ff))
    else $error("pitch changed inside one tone");
  chk_tone_legal: assert property (tone_kind_ff != 2'h3)
    else $error("undefined tone kind");
  chk_launch_quiet: assert property (launch_write |-> ##2 quiet_run)
    else $error("sound after launch");
  chk_fire_hold: assert property (main_fire_ff |=> main_fire_ff)
    else $error("main firing dropped");
  chk_fire_cause: assert property ($rose(main_fire_ff) |->
    ($past(supply_ok) || $past(supply_ok, 2)) && ($past(descending) || $past(descending, 2))
    && ($past(alt_ft) <= {3'h0, MDA_MAX} || $past(alt_ft, 2) <= {3'h0, MDA_MAX}))
    else $error("main fired without descent supply or altitude");
endmodule : beep_report_sequencer_chk

bind beep_report_sequencer beep_report_sequencer_chk #(.SHORT_CYC(SHORT_CYC),
  .SEP_CYC(SEP_CYC), .XLONG_CYC(XLONG_CYC), .WARN_CYC(WARN_CYC), .SIREN_CYC(SIREN_CYC))
  i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata_ff(rdata_ff), .supply_ok(supply_ok), .descending(descending),
  .alt_ft(alt_ft), .beep_on_ff(beep_on_ff), .tone_kind_ff(tone_kind_ff),
  .main_fire_ff(main_fire_ff));

// ===== verif/tb_beep_report_sequencer.sv
// testbench for the beep report sequencer: reports, continuity, flight
// assumes the listener model and the bound checker are compiled alongside
`timescale 1ns/10ps

module tb_beep_report_sequencer
  import beep_report_pkg::*;
;
  localparam int SH = 2;
  localparam int SEP = 4;
  localparam int XL = 6;
  localparam int WRN = 7;
  localparam int SIR = 9;
  localparam int CONT = 20;

  logic clk, rst_n, wr_en, rd_en, supply_ok, drogue_cont, main_cont, descending;
  logic [3:0] addr;
  logic [31:0] wdata, rd_val;
  logic [16:0] alt_ft;
  logic [23:0] pressure;
  logic [31:0] rdata_ff;
  logic beep_on_ff, main_fire_ff;
  logic [1:0] tone_kind_ff;
  int bad_count, checks, i;
  int exp_len[$], exp_tone[$];

  // short counts keep every report well inside the run length budget
  beep_report_sequencer #(.SHORT_CYC(SH), .SEP_CYC(SEP), .GAP_CYC(1), .DIGIT_GAP_CYC(2),
    .XLONG_CYC(XL), .SEC_CYC(3), .PAUSE_CYC(5), .WARN_CYC(WRN), .SIREN_CYC(SIR),
    .SILENCE_CYC(10), .CONT_CYC(CONT)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff),
    .supply_ok(supply_ok), .drogue_cont(drogue_cont), .main_cont(main_cont),
    .descending(descending), .alt_ft(alt_ft), .pressure(pressure),
    .beep_on_ff(beep_on_ff), .tone_kind_ff(tone_kind_ff), .main_fire_ff(main_fire_ff));

  beeper_listener i_ear (.clk(clk), .rst_n(rst_n), .beep_on_ff(beep_on_ff),
    .tone_kind_ff(tone_kind_ff));

  always #12.5 clk = ~clk;

  task tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_val = rdata_ff;
  endtask : rd

  task do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    i_ear.run_len.delete();
    i_ear.run_tone.delete();
  endtask : do_reset

  task add_run(input int len, input int tone);
    exp_len.push_back(len);
    exp_tone.push_back(tone);
  endtask : add_run

  // separator, then one group per digit, most significant first, zero as ten
  task add_num(input int v, input int tone);
    int p, d;
    p = 1;
    while (p * 10 <= v)
      p = p * 10;
    add_run(SEP, tone);
    for (; p > 0; p = p / 10)
    begin
      d = (v / p) % 10;
      repeat (d == 0 ? 10 : d) add_run(SH, tone);
    end
  endtask : add_num

  // a tone of -1 means the pitch is left open
  task listen();
    int n;
    for (n = 0; n < 4000 && i_ear.run_len.size() < exp_len.size(); n++)
      @(posedge clk);
    if (n == 4000)
    begin
      bad_count++;
      tally_and_finish();
    end
    foreach (exp_len[k])
    begin
      check("run length", exp_len[k], i_ear.run_len[k]);
      if (exp_tone[k] >= 0)
        check("run tone", exp_tone[k], i_ear.run_tone[k]);
    end
    exp_len.delete();
    exp_tone.delete();
    i_ear.run_len.delete();
    i_ear.run_tone.delete();
  endtask : listen

  task powerup_default();
    do_reset();
    wr(A_LAST_APO, 32'h000000A0);
    wr(A_BATT, 32'h0000005C);
    wr(A_FLAGS, 32'h00000000);
    wr(A_PEAK, 32'h00003110);
    wr(A_MAX_VEL, 32'h0000002D);
    rd(A_PRESET);
    check("preset", 32'h00000003, rd_val);
    rd(A_MDA);
    check("main altitude", 32'h000002BC, rd_val);
    rd(A_SIREN_DLY);
    check("siren delay", 32'h00000005, rd_val);
    add_num(3, 0);
    add_num(700, 0);
    add_num(160, 0);
    add_num(92, 0);
    listen();
  endtask : powerup_default

  task continuity_codes();
    int r0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      drogue_cont <= i[0];
      main_cont <= i[1];
      pressure <= 24'h010000 + 24'(i);
      repeat (3 * CONT) @(posedge clk);
      r0 = i_ear.rises;
      repeat (3 * CONT) @(posedge clk);
      check("continuity beeps", 3 * i, i_ear.rises - r0);
      rd(A_GROUND);
      check("ground", 32'h00010000 + i, rd_val);
    end
    @(posedge clk);
    drogue_cont <= 1'b0;
    main_cont <= 1'b0;
  endtask : continuity_codes

  task powerloss_report();
    do_reset();
    wr(A_APO_DLY, 32'h00000002);
    wr(A_FLAGS, 32'h00000001);
    wr(A_MDA, 32'h00000032);
    wr(A_BATT, 32'h0000005C);
    rd(A_PEAK);
    check("peak kept", 32'h00003110, rd_val);
    add_num(3, 0);
    add_num(100, 0);
    add_run(WRN, -1);
    add_run(SIR, 2);
    add_num(92, 0);
    listen();
  endtask : powerloss_report

  task flight_fire();
    // let continuity start so the ground reference is tracked before launch
    repeat (CONT) @(posedge clk);
    wr(A_SIREN_DLY, 32'h00000001);
    wr(A_CTRL, 32'h00000004);
    @(posedge clk);
    pressure <= 24'h0ABCDE;
    descending <= 1'b1;
    alt_ft <= 17'd150;
    repeat (5) @(posedge clk);
    rd(A_GROUND);
    check("ground frozen", 32'h00010003, rd_val);
    check("main early", 32'h0, main_fire_ff);
    @(posedge clk);
    alt_ft <= 17'd100;
    repeat (3) @(posedge clk);
    check("main fire", 32'h1, main_fire_ff);
    i_ear.run_len.delete();
    i_ear.run_tone.delete();
    wr(A_CTRL, 32'h00000002);
    add_run(XL, 0);
    add_num(12560, 0);
    add_num(45, 1);
    add_run(SIR, 2);
    add_run(XL, 0);
    listen();
    rd(A_FLAGS);
    check("loss flag", 32'h00000000, rd_val);
  endtask : flight_fire

  task fire_no_supply();
    do_reset();
    supply_ok <= 1'b0;
    wr(A_CTRL, 32'h00000004);
    alt_ft <= 17'd0;
    repeat (5) @(posedge clk);
    supply_ok <= 1'b1;
    repeat (5) @(posedge clk);
    check("no retry", 32'h0, main_fire_ff);
    rd(A_MAIN);
    check("attempt used", 32'h00000002, rd_val);
  endtask : fire_no_supply

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    supply_ok = 1'b1;
    drogue_cont = 1'b1;
    main_cont = 1'b1;
    descending = 1'b0;
    alt_ft = 17'h1FFFF;
    pressure = 24'h012345;
    powerup_default();
    continuity_codes();
    powerloss_report();
    flight_fire();
    fire_no_supply();
    tally_and_finish();
  end
endmodule : tb_beep_report_sequencer
